// ### inc/rsp_pkg.sv
// Purpose: shared constants and types of the redundancy state panel controller
// Assumes: 200 MHz pclk
// Notes:   counts above 4096 cycles reappear as top-level parameters
package rsp_pkg;
    // ==========================================
    // timing
    localparam int unsigned CLK_HZ        = 200_000_000;
    localparam int unsigned CYC_PER_MS    = CLK_HZ / 1000;
    localparam int unsigned HOLD_MS       = 1000;
    localparam int unsigned BLINK_HALF_MS = 500;
    localparam int unsigned RECENT_MS     = 2000;
    localparam int unsigned HOLD_CYCLES   = HOLD_MS * CYC_PER_MS;
    localparam int unsigned BLINK_CYCLES  = BLINK_HALF_MS * CYC_PER_MS;
    localparam int unsigned RECENT_CYCLES = RECENT_MS * CYC_PER_MS;
    // ==========================================
    // register map
    localparam logic [11:0] ADDR_CTRL   = 12'h000;
    localparam logic [11:0] ADDR_CONFIG = 12'h004;
    localparam logic [11:0] ADDR_STATUS = 12'h008;
    localparam int CTRL_STANDBY_BIT = 0;
    localparam int CTRL_PARK_BIT    = 1;
    localparam int CTRL_REVIVE_BIT  = 2;
    localparam int CFG_SYNC_DIS_BIT = 0;
    localparam int ST_STATE_LSB     = 0;
    localparam int ST_LED_LSB       = 4;
    localparam int ST_RELAY_BIT     = 8;
    localparam int ST_RECENT_BIT    = 9;
    localparam int ST_PEND_BIT      = 10;
    localparam logic CFG_SYNC_DIS_RST = 1'b0;
    localparam logic PEND_RST         = 1'b1;
    // ==========================================
    // types
    typedef enum logic [2:0] {
        ST_NOTCFG, ST_START, ST_ACTIVE, ST_STANDBY, ST_INACTIVE
    } rsp_state_type;
    typedef enum logic [1:0] {
        FB_OFF, FB_PASSIVE, FB_ACTIVE
    } rsp_fb_type;
    typedef struct packed {
        logic revive;
        logic park;
        logic standby;
    } rsp_cmd_type;
    typedef struct packed {
        logic inactive;
        logic standby;
        logic active;
    } rsp_led_type;
    typedef struct packed {
        logic          known;
        rsp_state_type state;
    } rsp_peer_type;
    typedef struct packed {
        logic start_done;
        logic fault_notcfg;
        logic fault_inactive;
        logic project_differs;
        logic sync_ok;
    } rsp_cond_type;
endpackage : rsp_pkg

// ### rtl/rsp_ctrl.sv
// Purpose: one half of a redundant controller pair: state machine, panel, relay
// Assumes: inputs synchronous to pclk; peer status and checks come from outside
// Notes:   peer status and checks are levels; peer and software commands are one-cycle pulses
// How it works
// - inactive keeps fieldbus masters in passive mode only
// - inactive exits only to not-configured with configuration pending
// - starting ends in standby_request_button, active, inactive or not-configured by checks
// - three buttons in, three indicators and one relay out
// - this half drives only the relay that powers off its peer
// - standby press in active requests move to standby_request_button
// - standby press in not-configured raises configuration request
// - standby press in inactive goes to not-configured with request pending
// - park press in standby_request_button moves to inactive
// - revive press releases the peer shutdown relay
// - press accepted after one second held alone
// - software and peer commands act exactly like button presses
// - indicators: none, all, active, standby, inactive per state
// - blinking is half second lit, half second dark
// - first two seconds active: active indicator blinks, exits ignored
// - active and killing peer blinks standby indicator, else off
// - transitions from one state tested in ascending number order
// - conditions inside a transition tested in listed order
// - no transitions unless powered and task running; else not-configured
// - not-configured held while peer active and projects differ, unless disabled
// - pending request on entry to not-configured starts without operator
// - taking active with peer unknown powers peer off via relay
// - starting goes standby_request_button when peer active and sync services work
// - standby_request_button goes active when peer state known and not active
//
// The APB register port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
module rsp_ctrl
    import rsp_pkg::*;
#(
    parameter int unsigned HOLD_CYC   = HOLD_CYCLES,
    parameter int unsigned BLINK_CYC  = BLINK_CYCLES,
    parameter int unsigned RECENT_CYC = RECENT_CYCLES
) (
    // clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         ce,
    // apb slave
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [11:0]  paddr,
    input  wire logic [31:0]  pwdata,
    output var  logic [31:0]  prdata,
    output var  logic         pready,
    output var  logic         pslverr,
    // half status and checks
    input  wire logic         powered,
    input  wire logic         task_running,
    input  wire rsp_cond_type cond,
    input  wire rsp_peer_type peer,
    input  wire rsp_cmd_type  peer_cmd,
    // panel
    input  wire rsp_cmd_type  buttons,
    output var  rsp_led_type  leds,
    output var  logic         peer_shutdown_relay,
    // fieldbus and state
    output var  rsp_fb_type   fieldbus_mode,
    output var  rsp_state_type state
);
    // ==========================================
    // helpers
    function automatic logic onehot3(input rsp_cmd_type v);
        onehot3 = (v == 3'h1) || (v == 3'h2) || (v == 3'h4);
    endfunction : onehot3

    function automatic logic at_lim(input logic [31:0] c, input int unsigned lim);
        at_lim = (c == 32'(lim - 1));
    endfunction : at_lim

    rsp_state_type state_q, state_d;
    logic          pend_q, pend_d, recent_q, blink_q, relay_q, kill_set;
    logic          sync_dis_q, run_ok, wr, rd_setup, bad_addr;
    logic [31:0]   hold_cnt_q, blink_cnt_q, recent_cnt_q;
    rsp_cmd_type   held_q, btn_fire, sw_cmd, cmd;
    logic          fired_q, peer_act, peer_stby, block;

    // ==========================================
    // apb slave
    assign wr       = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    assign bad_addr = (paddr != ADDR_CTRL) && (paddr != ADDR_CONFIG) && (paddr != ADDR_STATUS);
    assign pready   = 1'b1;
    assign pslverr  = psel && penable && bad_addr;

    assign sw_cmd = (wr && paddr == ADDR_CTRL)
                  ? rsp_cmd_type'({pwdata[CTRL_REVIVE_BIT], pwdata[CTRL_PARK_BIT], pwdata[CTRL_STANDBY_BIT]})
                  : rsp_cmd_type'(3'h0);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_dis_q <= CFG_SYNC_DIS_RST;
        end else if (ce && wr && paddr == ADDR_CONFIG) begin
            sync_dis_q <= pwdata[CFG_SYNC_DIS_BIT];
        end
    end

    // read data latched in setup so it is stable for the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (ce && rd_setup) begin
            prdata <= 32'h0000_0000;
            if (paddr == ADDR_CONFIG) begin
                prdata[CFG_SYNC_DIS_BIT] <= sync_dis_q;
            end else if (paddr == ADDR_STATUS) begin
                prdata[ST_STATE_LSB +: 3] <= state_q;
                prdata[ST_LED_LSB +: 3]   <= leds;
                prdata[ST_RELAY_BIT]      <= relay_q;
                prdata[ST_RECENT_BIT]     <= recent_q;
                prdata[ST_PEND_BIT]       <= pend_q;
            end
        end
    end

    // ==========================================
    // button qualification
    // one second held alone
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            held_q     <= rsp_cmd_type'(3'h0);
            hold_cnt_q <= 32'h0000_0000;
            fired_q    <= 1'b0;
        end else if (ce) begin
            // restart on release or other press
            if (buttons != held_q || !onehot3(buttons)) begin
                held_q     <= buttons;
                hold_cnt_q <= 32'h0000_0000;
                fired_q    <= 1'b0;
            end else if (!fired_q && at_lim(hold_cnt_q, HOLD_CYC)) begin
                fired_q <= 1'b1;
            end else if (!fired_q) begin
                hold_cnt_q <= hold_cnt_q + 32'h0000_0001;
            end
        end
    end

    assign btn_fire = (onehot3(buttons) && buttons == held_q && !fired_q && at_lim(hold_cnt_q, HOLD_CYC))
                    ? held_q : rsp_cmd_type'(3'h0);
    assign cmd = btn_fire | sw_cmd | peer_cmd;

    // ==========================================
    // timers
    // blink phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            blink_cnt_q <= 32'h0000_0000;
            blink_q     <= 1'b0;
        end else if (ce) begin
            if (at_lim(blink_cnt_q, BLINK_CYC)) begin
                blink_cnt_q <= 32'h0000_0000;
                blink_q     <= !blink_q;
            end else begin
                blink_cnt_q <= blink_cnt_q + 32'h0000_0001;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            recent_cnt_q <= 32'h0000_0000;
            recent_q     <= 1'b0;
        end else if (ce) begin
            if (state_d == ST_ACTIVE && state_q != ST_ACTIVE) begin
                recent_cnt_q <= 32'h0000_0000;
                recent_q     <= 1'b1;
            end else if (state_q != ST_ACTIVE || at_lim(recent_cnt_q, RECENT_CYC)) begin
                recent_q <= 1'b0;
            end else begin
                recent_cnt_q <= recent_cnt_q + 32'h0000_0001;
            end
        end
    end

    // ==========================================
    // state machine
    assign run_ok    = powered && task_running;
    assign peer_act  = peer.known && peer.state == ST_ACTIVE;
    assign peer_stby = peer.known && peer.state == ST_STANDBY;
    assign block     = peer_act && cond.project_differs && !sync_dis_q;

    always_comb begin
        state_d  = state_q;
        pend_d   = pend_q;
        kill_set = 1'b0;
        if (!run_ok) begin
            state_d = ST_NOTCFG;
            pend_d  = 1'b1;
        end else begin
            unique case (state_q)
                ST_NOTCFG: begin
                    if (!block && (pend_q || cmd.standby)) begin
                        state_d = ST_START;
                        pend_d  = 1'b0;
                    end
                end
                ST_START: begin
                    if (cond.start_done) begin
                        if (cond.fault_notcfg) begin
                            state_d = ST_NOTCFG;
                            pend_d  = block;
                        end else if (cond.fault_inactive || (peer_act && !cond.sync_ok)) begin
                            state_d = ST_INACTIVE;
                        end else if (!peer_act) begin
                            state_d  = ST_ACTIVE;
                            kill_set = !peer.known;
                        end else begin
                            state_d = ST_STANDBY;
                        end
                    end
                end
                ST_ACTIVE: begin
                    if (!recent_q) begin
                        if (cond.fault_inactive && peer_stby) begin
                            state_d = ST_INACTIVE;
                        end else if (cmd.standby && peer_stby) begin
                            state_d = ST_STANDBY;
                        end
                    end
                end
                ST_STANDBY: begin
                    if (cond.fault_notcfg) begin
                        state_d = ST_NOTCFG;
                        pend_d  = block;
                    end else if (cond.fault_inactive || cmd.park) begin
                        state_d = ST_INACTIVE;
                    end else if (!peer.known) begin
                        state_d  = ST_ACTIVE;
                        kill_set = 1'b1;
                    end else if (!peer_act) begin
                        state_d = ST_ACTIVE;
                    end
                end
                ST_INACTIVE: begin
                    if (cmd.standby) begin
                        state_d = ST_NOTCFG;
                        pend_d  = 1'b1;
                    end
                end
                default: begin
                    state_d = ST_NOTCFG;
                    pend_d  = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_NOTCFG;
            pend_q  <= PEND_RST;
        end else if (ce) begin
            state_q <= state_d;
            pend_q  <= pend_d;
        end
    end

    assign state = state_q;

    // ==========================================
    // relay
    // peer relay; a set beats a revive in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            relay_q <= 1'b0;
        end else if (ce) begin
            if (kill_set) begin
                relay_q <= 1'b1;
            end else if (cmd.revive) begin
                relay_q <= 1'b0;
            end
        end
    end

    assign peer_shutdown_relay = relay_q;

    // ==========================================
    // indicators and fieldbus
    // state patterns
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            leds          <= rsp_led_type'(3'h0);
            fieldbus_mode <= FB_OFF;
        end else if (ce) begin
            unique case (state_q)
                ST_NOTCFG: begin
                    leds          <= rsp_led_type'(3'h0);
                    fieldbus_mode <= FB_OFF;
                end
                ST_START: begin
                    leds          <= rsp_led_type'(3'h7);
                    fieldbus_mode <= FB_PASSIVE;
                end
                ST_ACTIVE: begin
                    leds.active   <= recent_q ? blink_q : 1'b1;
                    leds.standby  <= relay_q && blink_q;
                    leds.inactive <= 1'b0;
                    fieldbus_mode <= FB_ACTIVE;
                end
                ST_STANDBY: begin
                    leds          <= rsp_led_type'(3'h2);
                    fieldbus_mode <= FB_PASSIVE;
                end
                ST_INACTIVE: begin
                    leds          <= rsp_led_type'(3'h4);
                    fieldbus_mode <= FB_PASSIVE;
                end
                default: begin
                    leds          <= rsp_led_type'(3'h0);
                    fieldbus_mode <= FB_OFF;
                end
            endcase
        end
    end

    // ==========================================
    // assertions
    AST_NOT_RUNNING: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && !run_ok) |=> (state_q == ST_NOTCFG && pend_q))
        else $error("not running but left not-configured");
    AST_INACTIVE_EXIT: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q == ST_INACTIVE) |=> (state_q inside {ST_INACTIVE, ST_NOTCFG}))
        else $error("illegal exit from inactive");
    AST_INACTIVE_PRESS: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && run_ok && state_q == ST_INACTIVE && cmd.standby) |=> (state_q == ST_NOTCFG && pend_q))
        else $error("standby press in inactive lost");
    AST_PEND_STARTS: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && run_ok && state_q == ST_NOTCFG && pend_q && !block) |=> (state_q == ST_START))
        else $error("pending request did not start");
    AST_BLOCKED: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && state_q == ST_NOTCFG && block) |=> (state_q == ST_NOTCFG))
        else $error("left not-configured with project mismatch");
    AST_RECENT_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && run_ok && state_q == ST_ACTIVE && recent_q) |=> (state_q == ST_ACTIVE))
        else $error("left active while recent");
    AST_PARK: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && run_ok && state_q == ST_STANDBY && cmd.park && !cond.fault_notcfg) |=> (state_q == ST_INACTIVE))
        else $error("park press ignored in standby_request_button");
    AST_FIRE_ONCE: assert property (@(posedge pclk) disable iff (!presetn)
        (btn_fire != 3'h0) |=> (btn_fire == 3'h0) [*2])
        else $error("button fired twice");
    AST_START_LEDS: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && state_q == ST_START) |=> (leds == 3'h7))
        else $error("starting indicators wrong");
    AST_PASSIVE: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && state_q == ST_INACTIVE) |=> (fieldbus_mode == FB_PASSIVE))
        else $error("fieldbus not passive in inactive");
    AST_KILL: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && kill_set) |=> (relay_q && state_q == ST_ACTIVE))
        else $error("peer not powered off");
endmodule : rsp_ctrl
`default_nettype wire

// ### tb/rsp_peer_model.sv
// Purpose: behavioural model of the peer half seen across the pair
// Assumes: bench drives the requests by non-blocking assignment at pclk rise
// Notes:   a closed shutdown relay powers the peer off, so its state is lost
`timescale 1ns/1ps
`default_nettype none
module rsp_peer_model
    import rsp_pkg::*;
(
    // clock and reset
    input  wire logic          pclk,
    input  wire logic          presetn,
    // bench requests
    input  wire logic          known_req,
    input  wire logic          follow,
    input  wire rsp_state_type st_req,
    input  wire rsp_cmd_type   cmd_req,
    // device side
    input  wire rsp_state_type dut_state,
    input  wire logic          relay,
    output var  rsp_peer_type  peer,
    output var  rsp_cmd_type   peer_cmd
);
    // ==========================================
    // peer state
    // relay powers peer off
    // follow mode keeps the pair complementary, as a real peer takes over
    always_comb begin
        peer.known = known_req && !relay;
        peer.state = st_req;
        if (follow) begin
            peer.state = (dut_state == ST_ACTIVE) ? ST_STANDBY : ST_ACTIVE;
        end
    end
    // ==========================================
    // peer commands
    // one-cycle command pulses
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            peer_cmd <= '0;
        end else begin
            peer_cmd <= cmd_req;
        end
    end
endmodule : rsp_peer_model
`default_nettype wire

// ### tb/tb_redundancy_state_panel_ctrl.sv
// Purpose: self-checking bench of the redundancy state panel controller
// Assumes: short hold, blink and recent counts; ce and task_running held high
// Notes:   register rows first, then the state walk through all five states
`timescale 1ns/1ps
`default_nettype none
module tb_redundancy_state_panel_ctrl;
    import rsp_pkg::*;
    localparam int unsigned HC = 8;
    localparam int unsigned BC = 4;
    localparam int unsigned RC = 16;
    typedef struct packed {
        logic [11:0] a;
        logic [31:0] d;
        logic [31:0] exp;
        logic        err;
    } rsp_row_type;
    localparam rsp_row_type ROWS [5] = '{
        '{ADDR_CONFIG, 32'h1, 32'h1, 1'b0}, '{ADDR_CONFIG, 32'h0, 32'h0, 1'b0},
        '{ADDR_CTRL, 32'h0, 32'h0, 1'b0}, '{12'h00C, 32'hFFFFFFFF, 32'h0, 1'b1},
        '{ADDR_STATUS, 32'hFFFFFFFF, 32'h400, 1'b0}};
    logic          pclk, presetn, psel, penable, pwrite, pready, pslverr, powered;
    logic          known_req, follow, relay, err, seen0, seen1;
    logic [11:0]   paddr;
    logic [31:0]   pwdata, prdata, rd;
    rsp_cond_type  cond;
    rsp_peer_type  peer;
    rsp_cmd_type   peer_cmd, cmd_req, buttons;
    rsp_led_type   leds;
    rsp_fb_type    fb;
    rsp_state_type state, st_req;
    int            err_total, check_count, cyc;

    rsp_ctrl #(.HOLD_CYC(HC), .BLINK_CYC(BC), .RECENT_CYC(RC)) i_rsp_ctrl (
        .pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .powered(powered), .task_running(1'b1), .cond(cond), .peer(peer),
        .peer_cmd(peer_cmd), .buttons(buttons), .leds(leds), .peer_shutdown_relay(relay),
        .fieldbus_mode(fb), .state(state));
    rsp_peer_model i_rsp_peer_model (
        .pclk(pclk), .presetn(presetn), .known_req(known_req), .follow(follow), .st_req(st_req),
        .cmd_req(cmd_req), .dut_state(state), .relay(relay), .peer(peer), .peer_cmd(peer_cmd));

    // ==========================================
    // clock and hang guard
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            close_out();
        end
    end
    // ==========================================
    // helpers
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // request held until pready is sampled high
    task automatic apb(input logic [11:0] a, input logic wr, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb
    task automatic wait_st(input rsp_state_type s);
        for (int i = 0; i < 64 && state !== s; i++) begin
            @(posedge pclk); #1;
        end
        chk(32'(state), 32'(s));
    endtask : wait_st
    task automatic press(input rsp_cmd_type b);
        @(posedge pclk);
        buttons <= b;
        repeat (HC + 3) @(posedge pclk);
        buttons <= '0;
    endtask : press
    task automatic blink(input int b);
        seen0 = 1'b0; seen1 = 1'b0;
        repeat (2 * BC + 2) begin
            @(posedge pclk); #1;
            if (leds[b] === 1'b1) seen1 = 1'b1; else seen0 = 1'b1;
        end
    endtask : blink
    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : close_out
    // ==========================================
    // main sequence
    initial begin
        presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = '0; pwdata = '0; powered = 0;
        cond = '0; known_req = 1; follow = 0; st_req = ST_STANDBY; cmd_req = '0; buttons = '0;
        err_total = 0; check_count = 0; cyc = 0;
        repeat (12) @(posedge pclk);
        #1;
        chk(32'(state), 32'(ST_NOTCFG));
        chk(32'(leds), 32'h0);
        @(posedge pclk);
        presetn <= 1'b1;
        foreach (ROWS[i]) begin
            apb(ROWS[i].a, 1'b1, ROWS[i].d);
            apb(ROWS[i].a, 1'b0, 32'h0);
            chk(rd, ROWS[i].exp);
            chk(32'(err), 32'(ROWS[i].err));
        end
        @(posedge pclk);
        powered <= 1'b1;
        wait_st(ST_START);
        repeat (2) @(posedge pclk); #1;
        chk(32'(leds), 32'h7);
        @(posedge pclk);
        cond.start_done <= 1'b1;
        wait_st(ST_ACTIVE);
        // an exit request inside the recent window must be dropped
        apb(ADDR_CTRL, 1'b1, 32'h1);
        #1 chk(32'(state), 32'(ST_ACTIVE));
        blink(0);
        chk({seen0, seen1}, 32'h3);
        repeat (RC) @(posedge pclk);
        blink(0);
        chk({seen0, seen1, leds.standby}, 32'h2);
        follow <= 1'b1;
        cmd_req <= 3'b001;
        @(posedge pclk);
        cmd_req <= '0;
        wait_st(ST_STANDBY);
        repeat (3) @(posedge pclk); #1;
        chk(32'(leds), 32'h2);
        press(3'b011);
        #1 chk(32'(state), 32'(ST_STANDBY));
        press(3'b010);
        wait_st(ST_INACTIVE);
        repeat (2) @(posedge pclk); #1;
        chk(32'(fb), 32'(FB_PASSIVE));
        cond.project_differs <= 1'b1;
        press(3'b001);
        wait_st(ST_NOTCFG);
        apb(ADDR_STATUS, 1'b0, 32'h0);
        chk(rd[ST_PEND_BIT], 32'h1);
        #1 chk(32'(state), 32'(ST_NOTCFG));
        cond.project_differs <= 1'b0;
        cond.sync_ok <= 1'b1;
        wait_st(ST_START);
        wait_st(ST_STANDBY);
        @(posedge pclk);
        known_req <= 1'b0;
        wait_st(ST_ACTIVE);
        repeat (2) @(posedge pclk); #1;
        chk(32'(relay), 32'h1);
        blink(1);
        chk({seen0, seen1}, 32'h3);
        press(3'b100);
        repeat (2) @(posedge pclk); #1;
        chk(32'(relay), 32'h0);
        powered <= 1'b0;
        wait_st(ST_NOTCFG);
        close_out();
    end
endmodule : tb_redundancy_state_panel_ctrl
`default_nettype wire
